// ===== tmc_mode_ctrl.sv
// Transmitter mode controller: operate/standby mode, mute sub-state,
// operate inhibits, automatic standby and an AXI4-Lite register slave.
// Assumes pins arrive asynchronously; the AXI master shares CLK_SYS_I.
//
// Summary of operation
// RQ1 - Always exactly one mode: operate or standby.
// RQ2 - Mute stays in operate, 32 VDC on, IF processor muted.
// RQ3 - Mute while in operate on upconverter unlock or missing modules.
// RQ4 - Remote operate line low requests operate.
// RQ5 - Front-panel operate selection requests operate.
// RQ6 - Serial operate command requests operate.
// RQ7 - No operate entry while heatsink above 78 C.
// RQ8 - No operate entry while any mute fault is present.
// RQ9 - No operate entry while amplifier interlock is high.
// RQ10 - Standby keeps the output amplifier disabled.
// RQ11 - Remote standby line low enters standby.
// RQ12 - Front-panel standby key enters standby.
// RQ13 - Serial standby command enters standby.
// RQ14 - Auto-standby after ten seconds of continuous modulation loss.
// RQ15 - Return to operate by itself when modulation comes back.
// RQ16 - Operation permitted only while RF interlock loop is closed.
// RQ17 - Mute whenever RF interlock loop is open.
// RQ18 - No menu operate while faults present or remote standby held.
// RQ19 - Standby wins over operate in the same cycle.
module tmc_mode_ctrl #(
  parameter longint AUTO_CYC = tmc_pkg::AUTO_STBY_CYC
) (
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  SYS_RST_I,
  input  wire tmc_pkg::tmc_pins_s    PINS_I,
  input  wire tmc_pkg::tmc_axi_req_s AXI_REQ_I,
  output tmc_pkg::tmc_axi_rsp_s      AXI_RSP_O,
  output tmc_pkg::tmc_ctl_s          CTL_O,
  output logic                       IRQ_O
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  tmc_pkg::tmc_pins_s pin_m_r;
  tmc_pkg::tmc_pins_s pin_s_r;
  logic               op_key_d_r;
  logic               sb_key_d_r;

  // Two flops on every pin; idle levels keep reset quiet
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      pin_m_r <= '{rmt_oper_n: 1'b1, rmt_stby_n: 1'b1, default: 1'b0};
      pin_s_r <= '{rmt_oper_n: 1'b1, rmt_stby_n: 1'b1, default: 1'b0};
    end else begin
      pin_m_r <= PINS_I;
      pin_s_r <= pin_m_r;
    end
  end

  // Key edge detect looks only at the second stage
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      op_key_d_r <= 1'b0;
      sb_key_d_r <= 1'b0;
    end else begin
      op_key_d_r <= pin_s_r.operate_menu_selection;
      sb_key_d_r <= pin_s_r.standby_key;
    end
  end

  // ==========================================================
  // Registers and bus decode signals
  // ==========================================================
  localparam int IRQ_W_L = tmc_pkg::IRQ_W;
  logic [31:0]         ctrl_r;
  logic [IRQ_W_L-1:0]  irq_stat_r;
  logic [IRQ_W_L-1:0]  irq_stat_nxt;
  logic [IRQ_W_L-1:0]  irq_mask_r;
  logic [IRQ_W_L-1:0]  events;
  logic                cmd_oper;
  logic                cmd_stby;
  logic                aw_hold_r;
  logic                w_hold_r;
  logic [7:0]          aw_addr_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic                wr_go;
  logic                wr_hit;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Address decode, shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    return (a == tmc_pkg::OFS_CTRL) || (a == tmc_pkg::OFS_CMD) ||
           (a == tmc_pkg::OFS_STAT) || (a == tmc_pkg::OFS_IRQS) ||
           (a == tmc_pkg::OFS_IRQM);
  endfunction : mapped

  // ==========================================================
  // Mode logic
  // ==========================================================
  tmc_pkg::tmc_mode_e  mode_r;
  tmc_pkg::tmc_mode_e  mode_nxt;
  logic                auto_r;
  logic                auto_nxt;
  localparam int CNT_W_L = tmc_pkg::CNT_W;
  logic [CNT_W_L-1:0]  loss_cnt_r;
  logic                mute_flt;
  logic                inhibit;
  logic                rmt_stby;
  logic                sb_req;
  logic                op_req;
  logic                loss_done;
  logic                refuse;

  // Counter end point, cut to the counter width on purpose
  localparam logic [CNT_W_L-1:0] LOSS_LAST = CNT_W_L'(AUTO_CYC - 1);

  assign rmt_stby = ~pin_s_r.rmt_stby_n;
  assign mute_flt = pin_s_r.upc_unlock | pin_s_r.upc_absent
                  | pin_s_r.ifp_absent;                        // [RQ3]
  // Any of these keeps the transmitter out of operate
  assign inhibit  = pin_s_r.pa_overtemp                        // [RQ7]
                  | mute_flt                                   // [RQ8]
                  | pin_s_r.pa_ilk_high                        // [RQ9]
                  | pin_s_r.rf_ilk_open;                       // [RQ16]

  // Standby sources: remote level, panel key edge, serial write
  assign sb_req = rmt_stby                                     // [RQ11]
                | (pin_s_r.standby_key & ~sb_key_d_r)          // [RQ12]
                | cmd_stby;                                    // [RQ13]

  // Panel request also blocked by a held remote standby line
  assign op_req = ~pin_s_r.rmt_oper_n                          // [RQ4]
                | (pin_s_r.operate_menu_selection & ~op_key_d_r
                   & ~rmt_stby)                                // [RQ5] [RQ18]
                | cmd_oper;                                    // [RQ6]

  assign loss_done = (loss_cnt_r == LOSS_LAST);

  // Next mode; a single enum register can only hold one mode
  always_comb begin                                            // [RQ1]
    mode_nxt = mode_r;
    auto_nxt = auto_r;
    refuse   = 1'b0;
    unique case (mode_r)
      tmc_pkg::ST_OPER: begin
        if (sb_req) begin
          mode_nxt = tmc_pkg::ST_STBY;
          auto_nxt = 1'b0;
        end else if (loss_done) begin
          mode_nxt = tmc_pkg::ST_STBY;                         // [RQ14]
          auto_nxt = 1'b1;
        end
      end
      tmc_pkg::ST_STBY: begin
        if (sb_req) begin
          auto_nxt = 1'b0;                                     // [RQ19]
          refuse   = op_req;
        end else if (op_req || (auto_r && pin_s_r.mod_present)) begin
          if (inhibit) begin
            refuse = op_req;                                   // [RQ7] [RQ8] [RQ9]
          end else begin
            mode_nxt = tmc_pkg::ST_OPER;                       // [RQ15]
            auto_nxt = 1'b0;
          end
        end
      end
    endcase
  end

  // Mode register
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      mode_r <= tmc_pkg::ST_STBY;
      auto_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      auto_r <= auto_nxt;
    end
  end

  // Continuous modulation loss counter; any presence restarts it
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      loss_cnt_r <= '0;
    end else if (mode_r != tmc_pkg::ST_OPER || pin_s_r.mod_present ||
                 !ctrl_r[tmc_pkg::CTRL_AUTO_EN] || loss_done) begin
      loss_cnt_r <= '0;
    end else begin
      loss_cnt_r <= loss_cnt_r + CNT_W_L'(1);                  // [RQ14]
    end
  end

  // ==========================================================
  // Control outputs, all registered from next-state values
  // ==========================================================
  logic oper_nxt;
  logic mute_nxt;

  assign oper_nxt = (mode_nxt == tmc_pkg::ST_OPER);
  // Mute is a sub-state of operate only
  assign mute_nxt = oper_nxt & (mute_flt                       // [RQ3]
                  | pin_s_r.rf_ilk_open);                      // [RQ17]

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      CTL_O <= '{ifp_mute: 1'b1, default: 1'b0};
    end else begin
      CTL_O.operate      <= oper_nxt;
      CTL_O.mute         <= mute_nxt;
      CTL_O.sup32_enable <= oper_nxt;                          // [RQ2]
      CTL_O.ifp_mute     <= ~oper_nxt | mute_nxt;              // [RQ2]
      CTL_O.pa_enable    <= oper_nxt;                          // [RQ10]
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  // ==========================================================
  always_comb begin
    events = '0;
    events[tmc_pkg::EV_OPER]   = oper_nxt & (mode_r != tmc_pkg::ST_OPER);
    events[tmc_pkg::EV_STBY]   = ~oper_nxt & (mode_r == tmc_pkg::ST_OPER);
    events[tmc_pkg::EV_MUTE]   = mute_nxt & ~CTL_O.mute;
    events[tmc_pkg::EV_REFUSE] = refuse;
    events[tmc_pkg::EV_AUTO]   = auto_nxt & ~auto_r;
  end

  // Write-one-to-clear; a new event wins over a clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_go && aw_addr_r == tmc_pkg::OFS_IRQS && w_strb_r[0]) begin
      irq_stat_nxt = irq_stat_r & ~w_data_r[IRQ_W_L-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | events;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irq_stat_r <= '0;
      IRQ_O      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      IRQ_O      <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  assign wr_go  = aw_hold_r & w_hold_r & ~AXI_RSP_O.bvalid;
  assign wr_hit = mapped(aw_addr_r) && aw_addr_r != tmc_pkg::OFS_STAT;
  assign cmd_oper = wr_go && aw_addr_r == tmc_pkg::OFS_CMD && w_strb_r[0]
                    && w_data_r[tmc_pkg::CMD_OPER];
  assign cmd_stby = wr_go && aw_addr_r == tmc_pkg::OFS_CMD && w_strb_r[0]
                    && w_data_r[tmc_pkg::CMD_STBY];

  // Address and data captured in either order, one write at a time
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      aw_hold_r         <= 1'b0;
      w_hold_r          <= 1'b0;
      aw_addr_r         <= '0;
      w_data_r          <= '0;
      w_strb_r          <= '0;
      AXI_RSP_O.awready <= 1'b0;
      AXI_RSP_O.wready  <= 1'b0;
      AXI_RSP_O.bvalid  <= 1'b0;
      AXI_RSP_O.bresp   <= tmc_pkg::RESP_OK;
    end else begin
      AXI_RSP_O.awready <= ~aw_hold_r & ~AXI_RSP_O.awready;
      AXI_RSP_O.wready  <= ~w_hold_r & ~AXI_RSP_O.wready;
      if (AXI_REQ_I.awvalid && AXI_RSP_O.awready) begin
        aw_hold_r         <= 1'b1;
        aw_addr_r         <= AXI_REQ_I.awaddr;
        AXI_RSP_O.awready <= 1'b0;
      end
      if (AXI_REQ_I.wvalid && AXI_RSP_O.wready) begin
        w_hold_r         <= 1'b1;
        w_data_r         <= AXI_REQ_I.wdata;
        w_strb_r         <= AXI_REQ_I.wstrb;
        AXI_RSP_O.wready <= 1'b0;
      end
      if (wr_go) begin
        AXI_RSP_O.bvalid <= 1'b1;
        AXI_RSP_O.bresp  <= wr_hit ? tmc_pkg::RESP_OK : tmc_pkg::RESP_ERR;
      end
      // Hold both captures until the response is taken
      if (AXI_RSP_O.bvalid && AXI_REQ_I.bready) begin
        AXI_RSP_O.bvalid <= 1'b0;
        aw_hold_r        <= 1'b0;
        w_hold_r         <= 1'b0;
      end
    end
  end

  // Writable control and mask registers
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ctrl_r     <= tmc_pkg::CTRL_RST;
      irq_mask_r <= tmc_pkg::IRQM_RST;
    end else if (wr_go) begin
      if (aw_addr_r == tmc_pkg::OFS_CTRL) begin
        ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_0001;
      end
      if (aw_addr_r == tmc_pkg::OFS_IRQM && w_strb_r[0]) begin
        irq_mask_r <= w_data_r[IRQ_W_L-1:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  logic [31:0] rd_word;

  // Status word: mode, mute, auto flag, inhibit and raw faults
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (AXI_REQ_I.araddr)
      tmc_pkg::OFS_CTRL: rd_word = ctrl_r;
      tmc_pkg::OFS_STAT: rd_word = {22'h000000, pin_s_r.mod_present,
                                    pin_s_r.rf_ilk_open, pin_s_r.pa_ilk_high,
                                    pin_s_r.pa_overtemp, mute_flt, inhibit,
                                    rmt_stby, auto_r, CTL_O.mute,
                                    CTL_O.operate};
      tmc_pkg::OFS_IRQS: rd_word = {27'h0000000, irq_stat_r};
      tmc_pkg::OFS_IRQM: rd_word = {27'h0000000, irq_mask_r};
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  // One read at a time; answer one cycle after address is taken
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      AXI_RSP_O.arready <= 1'b0;
      AXI_RSP_O.rvalid  <= 1'b0;
      AXI_RSP_O.rdata   <= '0;
      AXI_RSP_O.rresp   <= tmc_pkg::RESP_OK;
    end else begin
      AXI_RSP_O.arready <= ~AXI_RSP_O.rvalid & ~AXI_RSP_O.arready
                           & ~AXI_REQ_I.arvalid;
      if (AXI_REQ_I.arvalid && !AXI_RSP_O.rvalid && !AXI_RSP_O.arready) begin
        AXI_RSP_O.arready <= 1'b1;
      end
      if (AXI_REQ_I.arvalid && AXI_RSP_O.arready) begin
        AXI_RSP_O.arready <= 1'b0;
        AXI_RSP_O.rvalid  <= 1'b1;
        AXI_RSP_O.rdata   <= rd_word;
        AXI_RSP_O.rresp   <= mapped(AXI_REQ_I.araddr) ? tmc_pkg::RESP_OK
                                                       : tmc_pkg::RESP_ERR;
      end
      if (AXI_RSP_O.rvalid && AXI_REQ_I.rready) begin
        AXI_RSP_O.rvalid <= 1'b0;
      end
    end
  end

endmodule : tmc_mode_ctrl

// ===== tmc_pkg.sv
// Package for the transmitter mode controller: register map, field
// positions, reset values, timing counts and carrier types.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
package tmc_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam longint CLK_HZ       = 100_000_000;
  localparam longint AUTO_STBY_S  = 10;              // Modulation loss time, seconds
  localparam longint AUTO_STBY_CYC = AUTO_STBY_S * CLK_HZ;
  localparam int     CNT_W        = 30;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQS = 8'h0C;
  localparam logic [7:0] OFS_IRQM = 8'h10;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_AUTO_EN = 0;
  localparam int CMD_OPER     = 0;
  localparam int CMD_STBY     = 1;
  localparam int IRQ_W        = 5;
  localparam int EV_OPER      = 0;  // Operate entered
  localparam int EV_STBY      = 1;  // Standby entered
  localparam int EV_MUTE      = 2;  // Mute applied
  localparam int EV_REFUSE    = 3;  // Operate request refused
  localparam int EV_AUTO      = 4;  // Automatic standby taken

  // ==========================================================
  // Reset values and responses
  // ==========================================================
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [4:0]  IRQM_RST = 5'h00;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic {ST_STBY, ST_OPER} tmc_mode_e;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } tmc_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } tmc_axi_rsp_s;

  // Pins from remote lines, front panel and module sensors
  typedef struct packed {
    logic rmt_oper_n;   // Remote operate line, low = request
    logic rmt_stby_n;   // Remote standby line, low = request
    logic operate_menu_selection;
    logic standby_key;
    logic upc_unlock;
    logic upc_absent;
    logic ifp_absent;
    logic pa_overtemp;  // Heatsink above 78 C
    logic pa_ilk_high;  // Amplifier not installed
    logic rf_ilk_open;  // RF system loop open
    logic mod_present;  // Modulation reported present
  } tmc_pins_s;

  typedef struct packed {
    logic operate;      // Top-level mode is operate
    logic mute;         // Operate with RF held off
    logic pa_enable;    // Output amplifier enable
    logic sup32_enable; // 32 VDC supply section enable
    logic ifp_mute;     // IF processor mute
  } tmc_ctl_s;

endpackage : tmc_pkg

// ===== tmc_mode_ctrl_checker.sv
// Concurrent checks on the mode controller ports: mode, mute, inhibits, bus.
// Assumes one clock domain and a synchronous active-high reset.
module tmc_mode_ctrl_checker #(
  parameter longint AUTO_CYC = 20
) (
  input wire logic                  CLK_SYS_I,
  input wire logic                  SYS_RST_I,
  input wire tmc_pkg::tmc_pins_s    PINS_I,
  input wire tmc_pkg::tmc_axi_req_s AXI_REQ_I,
  input wire tmc_pkg::tmc_axi_rsp_s AXI_RSP_O,
  input wire tmc_pkg::tmc_ctl_s     CTL_O,
  input wire logic                  IRQ_O
);
  // ==========================================================
  // Helpers
  // ==========================================================
  // Pin faults seen raw; held four cycles to cover the sync delay
  logic flt;
  logic blk;
  assign flt = PINS_I.upc_unlock | PINS_I.upc_absent | PINS_I.ifp_absent | PINS_I.rf_ilk_open;
  assign blk = flt | PINS_I.pa_overtemp | PINS_I.pa_ilk_high | !PINS_I.rmt_stby_n;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_flt_held;
    flt [*4];
  endsequence
  sequence s_stby_held;
    !PINS_I.rmt_stby_n [*4];
  endsequence
  // ==========================================================
  // Assertions
  // ==========================================================
  a_stby_outputs_off: assert property (!CTL_O.operate |-> !CTL_O.pa_enable &&
    !CTL_O.sup32_enable && CTL_O.ifp_mute && !CTL_O.mute) else $error("standby outputs");
  a_mute_shape: assert property (CTL_O.mute |-> CTL_O.operate &&
    CTL_O.sup32_enable && CTL_O.ifp_mute) else $error("mute outside operate");
  a_fault_mutes: assert property (s_flt_held ##0 CTL_O.operate |-> CTL_O.mute)
    else $error("fault without mute");
  a_remote_stby_wins: assert property (s_stby_held |-> !CTL_O.operate)
    else $error("remote standby ignored");
  a_entry_blocked: assert property ($rose(CTL_O.operate) |->
    !$past(blk, 2) && !$past(blk, 3)) else $error("operate entered while blocked");
  a_b_stands: assert property (AXI_RSP_O.bvalid && !AXI_REQ_I.bready |=>
    AXI_RSP_O.bvalid && $stable(AXI_RSP_O.bresp)) else $error("write response dropped");
  a_r_stands: assert property (AXI_RSP_O.rvalid && !AXI_REQ_I.rready |=> AXI_RSP_O.rvalid &&
    $stable(AXI_RSP_O.rdata) && $stable(AXI_RSP_O.rresp)) else $error("read data dropped");
  a_reset_idle: assert property ($fell(SYS_RST_I) |-> !CTL_O.operate && CTL_O.ifp_mute &&
    !IRQ_O && !AXI_RSP_O.bvalid && !AXI_RSP_O.rvalid) else $error("reset state wrong");
endmodule : tmc_mode_ctrl_checker

bind tmc_mode_ctrl tmc_mode_ctrl_checker #(.AUTO_CYC(AUTO_CYC)) i_chk (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .PINS_I(PINS_I), .AXI_REQ_I(AXI_REQ_I),
  .AXI_RSP_O(AXI_RSP_O), .CTL_O(CTL_O), .IRQ_O(IRQ_O));

// ===== tmc_panel_model.sv
// Far side of the pins: remote open-collector lines, panel keys, sensors.
// Assumes the bench asks for pull-downs and key presses on the system clock.
module tmc_panel_model #(
  parameter int KEY_CYC = 4
) (
  input  wire logic               clk_i,
  input  wire tmc_pkg::tmc_pins_s lvl_i,   // Sensor levels
  input  wire logic               pd_oper_i,
  input  wire logic               pd_stby_i,
  input  wire logic               oper_key_i,
  input  wire logic               stby_key_i,
  output tmc_pkg::tmc_pins_s      pins_o
);
  // ==========================================================
  // Key press stretch
  // ==========================================================
  // A human press lasts several cycles, never a single clock
  int ko;
  int ks;
  always_ff @(posedge clk_i) begin
    ko <= oper_key_i ? KEY_CYC : (ko > 0 ? ko - 1 : 0);
    ks <= stby_key_i ? KEY_CYC : (ks > 0 ? ks - 1 : 0);
  end
  // Released lines float high through their pull-ups
  always_comb begin
    pins_o                        = lvl_i;
    pins_o.rmt_oper_n             = !pd_oper_i;
    pins_o.rmt_stby_n             = !pd_stby_i;
    pins_o.operate_menu_selection = (ko > 0);
    pins_o.standby_key            = (ks > 0);
    pins_o.rf_ilk_open            = lvl_i.rf_ilk_open;
  end
endmodule : tmc_panel_model

// ===== tb_transmitter_mode_control.sv
// Self-checking bench for the mode controller against an integer model.
// Assumes the panel model on the pins and an AXI4-Lite master task set.
module tb_transmitter_mode_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint AUTO = 20;
  logic                  clk, rst, pdo, pds, ko, ks, irq;
  tmc_pkg::tmc_pins_s    lvl, pins;
  tmc_pkg::tmc_axi_req_s req;
  tmc_pkg::tmc_axi_rsp_s rsp;
  tmc_pkg::tmc_ctl_s     ctl;
  int                    fails, checks, m_oper;
  logic [31:0]           rd;
  logic [1:0]            rs;
  logic [7:0] i_ofs [4] = '{tmc_pkg::OFS_CTRL, tmc_pkg::OFS_CMD, tmc_pkg::OFS_IRQS,
                            tmc_pkg::OFS_IRQM};

  tmc_panel_model i_panel (.clk_i(clk), .lvl_i(lvl), .pd_oper_i(pdo), .pd_stby_i(pds),
    .oper_key_i(ko), .stby_key_i(ks), .pins_o(pins));
  tmc_mode_ctrl #(.AUTO_CYC(AUTO)) i_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PINS_I(pins),
    .AXI_REQ_I(req), .AXI_RSP_O(rsp), .CTL_O(ctl), .IRQ_O(irq));

  // ==========================================================
  // Helpers
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Bounded wait step; a hang ends the run
  task automatic tick(inout int n);
    @(negedge clk);
    n++;
    if (n > 300) begin
      fails++;
      $display("MISMATCH t=%0t bus wait expired", $time);
      print_verdict();
    end
  endtask : tick
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, ta, tw;
    n = 0; ha = 1'b0; hw = 1'b0;
    @(posedge clk);
    req.awaddr <= a; req.awvalid <= 1'b1; req.wdata <= d; req.wstrb <= 4'hF; req.wvalid <= 1'b1;
    while (!(ha && hw)) begin
      tick(n);
      ta = !ha && rsp.awready;
      tw = !hw && rsp.wready;
      @(posedge clk);
      if (ta) begin ha = 1'b1; req.awvalid <= 1'b0; end
      if (tw) begin hw = 1'b1; req.wvalid <= 1'b0; end
    end
    do tick(n); while (!rsp.bvalid);
    rs = rsp.bresp;
    @(posedge clk); req.bready <= 1'b1;
    @(posedge clk); req.bready <= 1'b0;
  endtask : wr
  // Ready raised late on purpose so the answer must stand
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk); req.araddr <= a; req.arvalid <= 1'b1;
    do tick(n); while (!rsp.arready);
    @(posedge clk); req.arvalid <= 1'b0;
    do tick(n); while (!rsp.rvalid);
    rd = rsp.rdata; rs = rsp.rresp;
    @(posedge clk); req.rready <= 1'b1;
    @(posedge clk); req.rready <= 1'b0;
  endtask : rdr
  task automatic chk_mode(input int mu);
    chk(32'(ctl.operate), 32'(m_oper), "operate");
    chk(32'(ctl.pa_enable), 32'(m_oper), "amp enable");
    chk(32'(ctl.sup32_enable), 32'(m_oper), "supply");
    chk(32'(ctl.mute), 32'(mu), "mute");
    chk(32'(ctl.ifp_mute), 32'(m_oper == 0 || mu != 0), "ifp mute");
  endtask : chk_mode
  task automatic set_flt(input int i, input logic v);
    @(posedge clk);
    case (i)
      0: lvl.upc_unlock <= v;
      1: lvl.upc_absent <= v;
      2: lvl.ifp_absent <= v;
      3: lvl.rf_ilk_open <= v;
      4: lvl.pa_overtemp <= v;
      default: lvl.pa_ilk_high <= v;
    endcase
  endtask : set_flt
  // Source 0 remote line, 1 panel, 2 serial; model follows the request
  task automatic ask(input int src, input int op);
    int blk;
    @(posedge clk);
    // Read after the edge so a fault set just before has landed
    blk = int'(lvl.upc_unlock | lvl.upc_absent | lvl.ifp_absent | lvl.rf_ilk_open |
               lvl.pa_overtemp | lvl.pa_ilk_high | pds);
    if (src == 0) begin pdo <= (op != 0); pds <= pds | (op == 0); end
    if (src == 1) begin ko <= (op != 0); ks <= (op == 0); end
    @(posedge clk); ko <= 1'b0; ks <= 1'b0;
    if (src == 2) wr(tmc_pkg::OFS_CMD, (op != 0) ? 32'h1 : 32'h2);
    cyc(8);
    pdo <= 1'b0;
    if (src == 0) pds <= 1'b0;
    m_oper = (op == 0) ? 0 : ((blk != 0) ? m_oper : 1);
    cyc(4);
  endtask : ask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    lvl = '0; lvl.mod_present = 1'b1; req = '0; pdo = 1'b0; pds = 1'b0; ko = 1'b0; ks = 1'b0;
    rst = 1'b1; fails = 0; checks = 0; m_oper = 0;
    void'($urandom(71579));
    cyc(6); rst <= 1'b0; cyc(2);
    chk_mode(0);
    foreach (i_ofs[k]) begin rdr(i_ofs[k]); chk(rd, 32'h0, "reset read"); chk(32'(rs), 32'h0, "okay"); end
    rdr(8'h14); chk(32'(rs), 32'(tmc_pkg::RESP_ERR), "unmapped");
    wr(tmc_pkg::OFS_STAT, 32'h1); chk(32'(rs), 32'(tmc_pkg::RESP_ERR), "stat write");
    $display("test reset done");
    for (int s = 0; s < 3; s++) begin
      ask(s, 1); chk_mode(0);
      ask(int'($urandom_range(0, 2)), 0); chk_mode(0);
    end
    $display("test sources done");
    wr(tmc_pkg::OFS_IRQS, 32'h1F);
    for (int i = 0; i < 6; i++) begin
      set_flt(i, 1'b1); ask(int'($urandom_range(0, 2)), 1); chk_mode(0);
      set_flt(i, 1'b0); cyc(6);
    end
    rdr(tmc_pkg::OFS_IRQS); chk(32'(rd[tmc_pkg::EV_REFUSE]), 32'h1, "refused event");
    @(posedge clk); pds <= 1'b1; cyc(6);
    ask(1, 1); chk_mode(0);
    pds <= 1'b0;
    $display("test inhibits done");
    ask(2, 1);
    for (int i = 0; i < 4; i++) begin
      set_flt(i, 1'b1); cyc(8); chk_mode(1);
      set_flt(i, 1'b0); cyc(8); chk_mode(0);
    end
    $display("test mute done");
    wr(tmc_pkg::OFS_IRQS, 32'h1F); wr(tmc_pkg::OFS_IRQM, 32'h2); cyc(2);
    chk(32'(irq), 32'h0, "irq idle");
    wr(tmc_pkg::OFS_CMD, 32'h3); cyc(3); m_oper = 0;
    chk_mode(0);
    chk(32'(irq), 32'h1, "irq on standby");
    rdr(tmc_pkg::OFS_IRQM); chk(rd, 32'h2, "mask");
    wr(tmc_pkg::OFS_IRQS, 32'h2); cyc(2); chk(32'(irq), 32'h0, "irq cleared");
    $display("test priority and irq done");
    wr(tmc_pkg::OFS_CTRL, 32'h1); ask(2, 1);
    @(posedge clk); lvl.mod_present <= 1'b0;
    cyc(int'(AUTO / 2)); chk_mode(0);
    cyc(int'(AUTO) + 10); m_oper = 0; chk_mode(0);
    rdr(tmc_pkg::OFS_IRQS); chk(32'(rd[tmc_pkg::EV_AUTO]), 32'h1, "auto event");
    @(posedge clk); lvl.mod_present <= 1'b1;
    cyc(8); m_oper = 1; chk_mode(0);
    $display("test auto standby done");
    print_verdict();
  end
  // Watchdog against a stuck run
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("MISMATCH t=%0t run limit reached", $time);
    print_verdict();
  end
endmodule : tb_transmitter_mode_control
